// File: design/startup_seq_pkg.sv
// constants and types shared by the start-up and fault sequencer
package startup_seq_pkg;

  // ==========================================================
  // clock and counter sizing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;
  localparam int unsigned CNT_W = 26;

  // ==========================================================
  // system sequencer timing
  localparam int unsigned WAKE_US = 150;
  localparam int unsigned WAKE_CYC = WAKE_US * CYC_PER_US;
  localparam int unsigned BOOT_US = 10;
  localparam int unsigned BOOT_CYC = BOOT_US * CYC_PER_US;
  localparam int unsigned LIGHT_LOAD_MS = 200;
  localparam int unsigned LIGHT_LOAD_CYC = LIGHT_LOAD_MS * CYC_PER_MS;
  localparam int unsigned FAULT_PAUSE_MS = 1000;
  localparam int unsigned FAULT_PAUSE_CYC = FAULT_PAUSE_MS * CYC_PER_MS;
  localparam int unsigned AVG_HIGH_MS = 2;
  localparam int unsigned AVG_HIGH_CYC = AVG_HIGH_MS * CYC_PER_MS;
  localparam int unsigned AVG_LOW_MS = 50;
  localparam int unsigned AVG_LOW_CYC = AVG_LOW_MS * CYC_PER_MS;

  // ==========================================================
  // disconnect detector timing and staircase
  localparam int unsigned IDLE_MS = 700;
  localparam int unsigned IDLE_CYC = IDLE_MS * CYC_PER_MS;
  localparam int unsigned DISCHARGE_MS = 350;
  localparam int unsigned DISCHARGE_CYC = DISCHARGE_MS * CYC_PER_MS;
  localparam int unsigned ZC_WINDOW_MS = 12;
  localparam int unsigned ZC_WINDOW_CYC = ZC_WINDOW_MS * CYC_PER_MS;
  localparam logic [1:0] TOP_STEP = 2'h3;
  localparam logic [2:0] MISS_LIMIT = 3'h4;

  // ==========================================================
  // enable vector layout and reset value
  localparam int unsigned EN_WAVE = 4;
  localparam int unsigned EN_RSUP = 3;
  localparam int unsigned EN_CLAMP = 2;
  localparam int unsigned EN_SS = 1;
  localparam int unsigned EN_FET = 0;
  localparam logic [4:0] EN_RESET = 5'h05;

  typedef enum logic [2:0] {
    ST_STARTUP, ST_FET_ON, ST_FET_OFF, ST_WAKEUP,
    ST_CHARGE_BOOT, ST_STEADY_RUN, ST_LIGHT_LOAD, ST_FAULT
  } sys_state_e;

  typedef enum logic [1:0] {DET_IDLE, DET_TEST, DET_DISCHARGE} det_state_e;

endpackage

// File: design/mains_disconnect_detector.sv
// staircase test current, disconnect confirmation and timed discharge
module mains_disconnect_detector #(
  parameter int unsigned IDLE_CYCLES = startup_seq_pkg::IDLE_CYC,
  parameter int unsigned DISCHARGE_CYCLES = startup_seq_pkg::DISCHARGE_CYC,
  parameter int unsigned WINDOW_CYCLES = startup_seq_pkg::ZC_WINDOW_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic mains_zero_cross_seen,
  output logic test_current_on,
  output logic [1:0] test_current_step,
  output logic filter_cap_discharge_request
);
  import startup_seq_pkg::*;

  det_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] step_q, step_d;
  logic [2:0] miss_q, miss_d;

  // ==========================================================
  // decode of counter end points
  wire idle_done = cnt_q == CNT_W'(IDLE_CYCLES - 1);
  wire win_done = cnt_q == CNT_W'(WINDOW_CYCLES - 1);
  wire dis_done = cnt_q == CNT_W'(DISCHARGE_CYCLES - 1);
  wire at_top = step_q == TOP_STEP;

  // next state of the detector
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + CNT_W'(1);
    step_d = step_q;
    miss_d = miss_q;
    unique case (state_q)
      DET_IDLE: if (idle_done) begin // [RL1]
        state_d = DET_TEST;
        cnt_d = '0;
        step_d = 2'h0;
        miss_d = 3'h0;
      end
      DET_TEST: if (mains_zero_cross_seen) begin // [RL3]
        state_d = DET_IDLE;
        cnt_d = '0;
      end else if (win_done) begin
        cnt_d = '0;
        if (!at_top) begin
          step_d = step_q + 2'h1;
        end else if (miss_q == MISS_LIMIT - 3'h1) begin // [RL2]
          state_d = DET_DISCHARGE;
        end else begin
          miss_d = miss_q + 3'h1;
        end
      end
      DET_DISCHARGE: if (dis_done) begin // [RL4]
        state_d = DET_IDLE;
        cnt_d = '0;
      end
      default: begin
        state_d = DET_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  // detector state registers, running in every system state
  always_ff @(posedge mclk) begin // [RL5] [RL21]
    if (reset) begin
      state_q <= DET_IDLE;
      cnt_q <= '0;
      step_q <= 2'h0;
      miss_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      miss_q <= miss_d;
    end
  end

  assign test_current_on = state_q == DET_TEST;
  assign test_current_step = step_q;
  assign filter_cap_discharge_request = state_q == DET_DISCHARGE;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_ZC_STOPS_TEST: assert property ( // [RL3]
    test_current_on && mains_zero_cross_seen |=> !test_current_on && cnt_q == '0)
    else $error("test current not stopped on zero crossing");
  AST_CONFIRM_AT_TOP: assert property ( // [RL2]
    $rose(filter_cap_discharge_request) |-> $past(at_top) && $past(miss_q) == 3'h3
      && !$past(mains_zero_cross_seen))
    else $error("discharge without four misses at top step");
  AST_DISCHARGE_LENGTH: assert property ( // [RL4]
    filter_cap_discharge_request |-> cnt_q < CNT_W'(DISCHARGE_CYCLES))
    else $error("discharge longer than its window");
  COV_DISCONNECT: cover property ($rose(filter_cap_discharge_request));
endmodule

// File: design/startup_fault_sequencer_xcap.sv
// system state and fault sequencer with mains disconnect discharge
// Behaviour
// [RL1] test staircase every 700 ms idle
// [RL2] four misses at top step confirm disconnect
// [RL3] any zero crossing stops test, back idle
// [RL4] discharge current held for 350 ms
// [RL5] disconnect detection runs in every state
// [RL6] discharge turns fet on, current to ground
// [RL7] latched: open supply switch, discharge, reclose
// [RL8] soft start from boot end to crossing
// [RL9] after soft start, analog supply, burst threshold
// [RL10] zcs operation pulls shared pin down
// [RL11] burst threshold tracks bulk voltage
// [RL12] fet charges supply until start threshold
// [RL13] boot charge holds bottom drive high
// [RL14] fault stops switching, permanent or paused
// [RL15] average current faults qualified 2/50 ms
// [RL16] start threshold differs by bias mode
// [RL17] separate discharge output from enables
// [RL18] fault state drops enables, waits 1 s
// [RL19] light load below burst over 200ms faults
// [RL20] wake-up state lasts 150 us
// [RL21] timers count clock, reset clears all
module startup_fault_sequencer_xcap #(
  parameter int unsigned IDLE_CYCLES = startup_seq_pkg::IDLE_CYC,
  parameter int unsigned DISCHARGE_CYCLES = startup_seq_pkg::DISCHARGE_CYC,
  parameter int unsigned WINDOW_CYCLES = startup_seq_pkg::ZC_WINDOW_CYC,
  parameter int unsigned AVG_HIGH_CYCLES = startup_seq_pkg::AVG_HIGH_CYC,
  parameter int unsigned AVG_LOW_CYCLES = startup_seq_pkg::AVG_LOW_CYC,
  parameter int unsigned LIGHT_LOAD_CYCLES = startup_seq_pkg::LIGHT_LOAD_CYC,
  parameter int unsigned FAULT_PAUSE_CYCLES = startup_seq_pkg::FAULT_PAUSE_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic system_ready,
  input wire logic supply_above_start_selfbias,
  input wire logic supply_above_start_extbias,
  input wire logic external_bias_mode,
  input wire logic supply_below_restart,
  input wire logic bulk_above_start,
  input wire logic bulk_below_stop,
  input wire logic bulk_overvoltage_fault,
  input wire logic regulated_supply_undervoltage,
  input wire logic over_temperature_fault,
  input wire logic output_overvoltage_fault,
  input wire logic peak_current_fault,
  input wire logic avg_current_fault_high,
  input wire logic avg_current_fault_low,
  input wire logic feedback_below_burst_level,
  input wire logic feedback_copy_below_softstart,
  input wire logic zero_current_switching_region,
  input wire logic mains_zero_cross_seen,
  input wire logic supply_regulation_latched,
  input wire logic fault_stops_permanently,
  output logic waveform_generator_enable,
  output logic regulated_supply_enable,
  output logic supply_clamp_enable,
  output logic soft_start_enable,
  output logic startup_fet_on,
  output logic filter_cap_discharge_request,
  output logic filter_cap_discharge_current,
  output logic fet_supply_switch_closed,
  output logic bottom_switch_drive,
  output logic shared_pin_pulldown,
  output logic soft_start_done,
  output logic feedback_uses_internal_analog_supply,
  output logic burst_threshold_tracks_bulk,
  output logic xcap_test_current_on,
  output logic [1:0] xcap_test_current_step,
  output logic system_in_fault
);
  import startup_seq_pkg::*;

  sys_state_e state_q, state_d;
  logic [CNT_W-1:0] seq_cnt_q, seq_cnt_d;
  logic [CNT_W-1:0] avg_high_cnt_q, avg_low_cnt_q;
  logic [4:0] en_q;
  logic boot_drive_q;
  logic ss_done_q, ss_done_d;
  logic zcs_pull_q;
  logic dis_cur_q, dis_cur_d;
  logic sw_open_q, sw_open_d;
  logic dis_req;

  // ==========================================================
  // enables for each system state
  function automatic logic [4:0] state_enables(input sys_state_e s);
    logic [4:0] e;
    e = 5'h00;
    unique case (s)
      ST_STARTUP: e = EN_RESET;
      ST_FET_ON: e[EN_FET] = 1'b1;
      ST_FET_OFF, ST_WAKEUP, ST_CHARGE_BOOT: e[EN_RSUP] = 1'b1;
      ST_STEADY_RUN, ST_LIGHT_LOAD: begin
        e[EN_WAVE] = 1'b1;
        e[EN_RSUP] = 1'b1;
        e[EN_SS] = 1'b1;
      end
      ST_FAULT: e = 5'h00; // [RL18]
    endcase
    return e;
  endfunction

  // ==========================================================
  // input qualification
  // start threshold picked by bias mode
  wire supply_above_switch_start = external_bias_mode ? // [RL16]
    supply_above_start_extbias : supply_above_start_selfbias;
  wire bulk_ok = bulk_above_start && !bulk_below_stop &&
    !bulk_overvoltage_fault && !regulated_supply_undervoltage;

  // average current faults must persist before they count
  wire avg_high_timeout = avg_current_fault_high && // [RL15]
    avg_high_cnt_q >= CNT_W'(AVG_HIGH_CYCLES - 1);
  wire avg_low_timeout = avg_current_fault_low && // [RL15]
    avg_low_cnt_q >= CNT_W'(AVG_LOW_CYCLES - 1);

  // faults that end a running or waking system
  wire run_fault = over_temperature_fault || bulk_overvoltage_fault ||
    bulk_below_stop || output_overvoltage_fault || peak_current_fault ||
    avg_high_timeout || avg_low_timeout || regulated_supply_undervoltage;
  wire early_fault = over_temperature_fault || bulk_overvoltage_fault;

  // timer end points on the shared sequence counter
  wire wake_done = seq_cnt_q == CNT_W'(WAKE_CYC - 1);
  wire boot_done = seq_cnt_q == CNT_W'(BOOT_CYC - 1);
  wire light_timeout = seq_cnt_q == CNT_W'(LIGHT_LOAD_CYCLES - 1);
  wire pause_done = seq_cnt_q == CNT_W'(FAULT_PAUSE_CYCLES - 1);

  // ==========================================================
  // system state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STARTUP: begin
        if (over_temperature_fault) state_d = ST_FAULT;
        else if (system_ready) state_d = ST_FET_ON;
      end
      ST_FET_ON: begin
        if (early_fault) state_d = ST_FAULT;
        else if (supply_above_switch_start && !supply_below_restart) begin
          state_d = ST_FET_OFF; // [RL12]
        end
      end
      ST_FET_OFF: begin
        if (early_fault) state_d = ST_FAULT;
        else if (supply_below_restart) state_d = ST_FET_ON;
        else if (bulk_ok) state_d = ST_WAKEUP;
      end
      ST_WAKEUP: begin
        if (run_fault) state_d = ST_FAULT;
        else if (supply_below_restart) state_d = ST_FET_ON;
        else if (wake_done && bulk_ok && !feedback_below_burst_level) begin
          state_d = ST_CHARGE_BOOT; // [RL20]
        end
      end
      ST_CHARGE_BOOT: begin
        if (run_fault) state_d = ST_FAULT;
        else if (supply_below_restart) state_d = ST_FET_ON;
        else if (boot_done) state_d = ST_STEADY_RUN; // [RL13]
      end
      ST_STEADY_RUN: begin
        if (run_fault) state_d = ST_FAULT;
        else if (supply_below_restart) state_d = ST_FET_ON;
        else if (ss_done_q && feedback_below_burst_level) state_d = ST_LIGHT_LOAD;
      end
      ST_LIGHT_LOAD: begin
        if (run_fault || light_timeout) state_d = ST_FAULT; // [RL19]
        else if (supply_below_restart) state_d = ST_FET_ON;
        else if (!feedback_below_burst_level) state_d = ST_STEADY_RUN;
      end
      ST_FAULT: begin
        // pause then restart, or hold until power-on reset
        if (!fault_stops_permanently && pause_done) state_d = ST_FET_ON; // [RL14] [RL18]
      end
    endcase
  end

  // sequence counter restarts on every state change, saturates otherwise
  assign seq_cnt_d = (state_d != state_q) ? '0 :
    (&seq_cnt_q) ? seq_cnt_q : seq_cnt_q + CNT_W'(1); // [RL21]

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_STARTUP;
      seq_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      seq_cnt_q <= seq_cnt_d;
    end
  end

  // consecutive-assertion counters for the average current faults
  always_ff @(posedge mclk) begin // [RL15]
    if (reset) begin
      avg_high_cnt_q <= '0;
      avg_low_cnt_q <= '0;
    end else begin
      avg_high_cnt_q <= !avg_current_fault_high ? '0 :
        (&avg_high_cnt_q) ? avg_high_cnt_q : avg_high_cnt_q + CNT_W'(1);
      avg_low_cnt_q <= !avg_current_fault_low ? '0 :
        (&avg_low_cnt_q) ? avg_low_cnt_q : avg_low_cnt_q + CNT_W'(1);
    end
  end

  // ==========================================================
  // soft start and shared pin
  // done once the feedback copy drops under the ramp
  assign ss_done_d = (state_d == ST_STEADY_RUN || state_d == ST_LIGHT_LOAD) &&
    (ss_done_q || (state_q == ST_STEADY_RUN && feedback_copy_below_softstart)); // [RL8]

  // registered outputs follow the next state, except the shared pin pulldown, which follows the zcs input
  always_ff @(posedge mclk) begin
    if (reset) begin
      en_q <= EN_RESET;
      boot_drive_q <= 1'b0;
      ss_done_q <= 1'b0;
      zcs_pull_q <= 1'b0;
    end else begin
      en_q <= state_enables(state_d);
      boot_drive_q <= state_d == ST_CHARGE_BOOT; // [RL13]
      ss_done_q <= ss_done_d;
      zcs_pull_q <= zero_current_switching_region; // [RL10]
    end
  end

  assign waveform_generator_enable = en_q[EN_WAVE];
  assign regulated_supply_enable = en_q[EN_RSUP];
  assign supply_clamp_enable = en_q[EN_CLAMP];
  assign soft_start_enable = en_q[EN_SS];
  assign bottom_switch_drive = boot_drive_q;
  assign shared_pin_pulldown = zcs_pull_q;
  assign soft_start_done = ss_done_q;
  // swap ramp for analog supply and reuse pin for burst level
  assign feedback_uses_internal_analog_supply = ss_done_q; // [RL9]
  assign burst_threshold_tracks_bulk = ss_done_q; // [RL9] [RL11]
  assign system_in_fault = state_q == ST_FAULT;

  // ==========================================================
  // mains disconnect detection and discharge path
  mains_disconnect_detector #(
    .IDLE_CYCLES(IDLE_CYCLES),
    .DISCHARGE_CYCLES(DISCHARGE_CYCLES),
    .WINDOW_CYCLES(WINDOW_CYCLES)
  ) u_detector (
    .mclk(mclk),
    .reset(reset),
    .mains_zero_cross_seen(mains_zero_cross_seen),
    .test_current_on(xcap_test_current_on),
    .test_current_step(xcap_test_current_step),
    .filter_cap_discharge_request(dis_req)
  );

  // latched supply: open switch first, reclose after current stops
  assign sw_open_d = (dis_req && supply_regulation_latched) || (dis_cur_q && sw_open_q); // [RL7]
  assign dis_cur_d = dis_req && (!supply_regulation_latched || sw_open_q); // [RL7]

  always_ff @(posedge mclk) begin
    if (reset) begin
      dis_cur_q <= 1'b0;
      sw_open_q <= 1'b0;
    end else begin
      dis_cur_q <= dis_cur_d;
      sw_open_q <= sw_open_d;
    end
  end

  assign filter_cap_discharge_request = dis_req; // [RL17]
  assign filter_cap_discharge_current = dis_cur_q; // current sinks to ground [RL6]
  assign startup_fet_on = en_q[EN_FET] || dis_cur_q; // [RL6]
  assign fet_supply_switch_closed = !sw_open_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_FAULT_ENABLES_OFF: assert property ( // [RL18]
    $past(state_q == ST_FAULT) && state_q == ST_FAULT |-> en_q == 5'h00)
    else $error("enable active in fault state");
  AST_WAKE_LENGTH: assert property ( // [RL20]
    state_q == ST_CHARGE_BOOT && $past(state_q) == ST_WAKEUP |->
      $past(seq_cnt_q) == CNT_W'(WAKE_CYC - 1))
    else $error("wake-up state left early");
  AST_BOOT_DRIVE: assert property ( // [RL13]
    $rose(state_q == ST_CHARGE_BOOT) |-> bottom_switch_drive [*8])
    else $error("bottom drive not held during boot charge");
  AST_FET_OFF_ON_START: assert property ( // [RL12]
    state_q == ST_FET_ON && !early_fault && supply_above_switch_start
      && !supply_below_restart |=> state_q == ST_FET_OFF ##1 !startup_fet_on || dis_cur_q)
    else $error("start-up fet not released at start threshold");
  AST_AVG_HIGH_QUAL: assert property ( // [RL15]
    state_q == ST_FAULT && $past(state_q) == ST_STEADY_RUN && $past(run_fault) |->
      $past(over_temperature_fault || bulk_overvoltage_fault || bulk_below_stop ||
      output_overvoltage_fault || peak_current_fault || regulated_supply_undervoltage ||
      avg_high_cnt_q >= CNT_W'(AVG_HIGH_CYCLES - 1) || avg_low_cnt_q >= CNT_W'(AVG_LOW_CYCLES - 1)))
    else $error("average current fault not qualified");
  AST_DISCHARGE_FET: assert property ( // [RL6]
    filter_cap_discharge_current |-> startup_fet_on)
    else $error("discharge without start-up fet");
  AST_LATCH_ORDER: assert property ( // [RL7]
    $rose(dis_cur_q) && supply_regulation_latched |-> $past(!fet_supply_switch_closed))
    else $error("switch not opened before discharge");
  AST_LATCH_RECLOSE: assert property ( // [RL7]
    $fell(dis_cur_q) && sw_open_q && !dis_req |=> fet_supply_switch_closed)
    else $error("switch not reclosed after discharge");
  AST_SS_DONE: assert property ( // [RL8]
    $rose(ss_done_q) |-> $past(state_q) == ST_STEADY_RUN && $past(feedback_copy_below_softstart))
    else $error("soft start ended without crossing");
  AST_ZCS_PIN: assert property ( // [RL10]
    zero_current_switching_region |=> shared_pin_pulldown)
    else $error("shared pin not pulled down in zcs region");

  COV_REACH_RUN: cover property (state_q == ST_STEADY_RUN && ss_done_q);
  COV_LIGHT_TIMEOUT: cover property (state_q == ST_LIGHT_LOAD ##1 state_q == ST_FAULT);
  COV_LATCH_DISCHARGE: cover property ($rose(dis_cur_q) && supply_regulation_latched);
endmodule

// File: tb/analog_front_model.sv
// behavioural model of the supply comparators and the mains zero-cross front end
module analog_front_model #(
  parameter int ZC_PERIOD = 7
) (
  input wire logic mclk,
  input wire logic mains_on,
  input wire logic startup_fet_on,
  input wire logic fet_supply_switch_closed,
  input wire logic filter_cap_discharge_current,
  output logic mains_zero_cross_seen,
  output logic supply_above_start_selfbias,
  output logic supply_above_start_extbias,
  output logic supply_below_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  int lvl = 0;
  int zc = 0;
  // ==========================================================
  // supply charges only through a connected fet, never from the sink
  always @(posedge mclk) begin
    if (startup_fet_on && fet_supply_switch_closed && !filter_cap_discharge_current && lvl < 40) begin
      lvl <= lvl + 1;
    end
    zc <= (zc + 1) % ZC_PERIOD;
    mains_zero_cross_seen <= mains_on && zc == 0;
  end
  // self bias needs a higher level than external bias
  assign supply_above_start_selfbias = lvl >= 30;
  assign supply_above_start_extbias = lvl >= 20;
  assign supply_below_restart = lvl < 4;
endmodule

// File: tb/testbench.sv
// self-checking bench for the start-up, fault and disconnect sequencer
module testbench import startup_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
  `define WAIT(c, lim) begin n = 0; while (!(c) && n < (lim)) begin cyc(1); n++; end end
  localparam int IDL = 40, DIS = 30, WIN = 20, AH = 20, AL = 50, LL = 60, FP = 40;
  logic mclk = 0, reset = 1, system_ready = 0, external_bias_mode = 0, bulk_above_start = 0;
  logic feedback_below_burst_level = 0, feedback_copy_below_softstart = 0, zero_current_switching_region = 0;
  logic supply_regulation_latched = 0, fault_stops_permanently = 0, mains_on = 1;
  logic [7:0] flt = 8'h00;
  wire mains_zero_cross_seen, supply_above_start_selfbias, supply_above_start_extbias, supply_below_restart;
  wire waveform_generator_enable, regulated_supply_enable, supply_clamp_enable, soft_start_enable;
  wire startup_fet_on, filter_cap_discharge_request, filter_cap_discharge_current, fet_supply_switch_closed;
  wire bottom_switch_drive, shared_pin_pulldown, soft_start_done, feedback_uses_internal_analog_supply;
  wire burst_threshold_tracks_bulk, xcap_test_current_on, system_in_fault;
  wire [1:0] xcap_test_current_step;
  wire [4:0] en = {waveform_generator_enable, regulated_supply_enable, supply_clamp_enable, soft_start_enable,
    startup_fet_on};
  int miscompares = 0, num_checks = 0, seed = 55, n, k;

  always #25 mclk = ~mclk;

  startup_fault_sequencer_xcap #(.IDLE_CYCLES(IDL), .DISCHARGE_CYCLES(DIS), .WINDOW_CYCLES(WIN),
    .AVG_HIGH_CYCLES(AH), .AVG_LOW_CYCLES(AL), .LIGHT_LOAD_CYCLES(LL), .FAULT_PAUSE_CYCLES(FP)) dut_u (
    .mclk, .reset, .system_ready, .supply_above_start_selfbias, .supply_above_start_extbias,
    .external_bias_mode, .supply_below_restart, .bulk_above_start, .bulk_below_stop(flt[1]),
    .bulk_overvoltage_fault(flt[0]), .regulated_supply_undervoltage(flt[2]), .over_temperature_fault(flt[3]),
    .output_overvoltage_fault(flt[4]), .peak_current_fault(flt[5]), .avg_current_fault_high(flt[6]),
    .avg_current_fault_low(flt[7]), .feedback_below_burst_level, .feedback_copy_below_softstart,
    .zero_current_switching_region, .mains_zero_cross_seen, .supply_regulation_latched, .fault_stops_permanently,
    .waveform_generator_enable, .regulated_supply_enable, .supply_clamp_enable, .soft_start_enable,
    .startup_fet_on, .filter_cap_discharge_request, .filter_cap_discharge_current, .fet_supply_switch_closed,
    .bottom_switch_drive, .shared_pin_pulldown, .soft_start_done, .feedback_uses_internal_analog_supply,
    .burst_threshold_tracks_bulk, .xcap_test_current_on, .xcap_test_current_step, .system_in_fault);

  analog_front_model front_u (.mclk, .mains_on, .startup_fet_on, .fet_supply_switch_closed,
    .filter_cap_discharge_current, .mains_zero_cross_seen, .supply_above_start_selfbias,
    .supply_above_start_extbias, .supply_below_restart);

  // ==========================================================
  // expectations
  function automatic logic [4:0] exp_en(sys_state_e s);
    case (s)
      ST_STARTUP: return EN_RESET;
      ST_FET_ON: return 5'h01;
      ST_FET_OFF, ST_WAKEUP, ST_CHARGE_BOOT: return 5'h08;
      ST_STEADY_RUN, ST_LIGHT_LOAD: return 5'h1a;
      default: return 5'h00;
    endcase
  endfunction
  function automatic int fault_lat(int i);
    return i < 6 ? 1 : (i == 6 ? AH : AL);
  endfunction

  task automatic cyc(input int c);
    repeat (c) @(negedge mclk);
  endtask
  task automatic bring_up();
    system_ready = 1;
    bulk_above_start = 1;
    `WAIT(waveform_generator_enable, 4000)
    `CHK("run enables", exp_en(ST_STEADY_RUN), en)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // watchdog at about twice the expected run length
  initial begin
    cyc(60000);
    miscompares++;
    complete_run();
  end

  // ==========================================================
  // main sequence
  initial begin
    external_bias_mode = 1'($random(seed));
    cyc(10);
    reset = 0;
    `CHK("reset enables", EN_RESET, en)
    `CHK("reset switch", 1'b1, fet_supply_switch_closed)
    system_ready = 1;
    cyc(1);
    `CHK("fet on enables", exp_en(ST_FET_ON), en)
    `WAIT(regulated_supply_enable, 200)
    `CHK("fet off enables", exp_en(ST_FET_OFF), en)
    `CHK("bias threshold", external_bias_mode ? 21 : 31, front_u.lvl)
    bulk_above_start = 1;
    `WAIT(bottom_switch_drive, 4000)
    `CHK("wake time", 1'b1, n >= WAKE_CYC - 1 && n <= WAKE_CYC + 2)
    `CHK("boot enables", exp_en(ST_CHARGE_BOOT), en)
    `WAIT(!bottom_switch_drive, 400)
    `CHK("boot time", 1'b1, n >= BOOT_CYC - 1 && n <= BOOT_CYC + 1)
    `CHK("run enables", exp_en(ST_STEADY_RUN), en)
    `CHK("soft start open", 1'b0, soft_start_done)
    feedback_copy_below_softstart = 1;
    cyc(2);
    `CHK("soft start end", 3'h7, {soft_start_done, feedback_uses_internal_analog_supply, burst_threshold_tracks_bulk})
    for (k = 0; k < 4; k++) begin
      zero_current_switching_region = 1'($random(seed));
      cyc(2);
      `CHK("pin pulldown", zero_current_switching_region, shared_pin_pulldown)
    end
    feedback_below_burst_level = 1;
    cyc(LL / 2);
    feedback_below_burst_level = 0;
    cyc(2);
    `CHK("short light load", 1'b0, system_in_fault)
    feedback_below_burst_level = 1;
    `WAIT(system_in_fault, LL + 10)
    `CHK("light load time", 1'b1, n >= LL - 1 && n <= LL + 3)
    `CHK("fault enables", 5'h00, en)
    feedback_below_burst_level = 0;
    `WAIT(!system_in_fault, FP + 10)
    `CHK("pause time", 1'b1, n >= FP - 1 && n <= FP + 2)
    $display("test sequencer done");
    // every fault source, the last one permanent
    for (k = 0; k < 8; k++) begin
      bring_up();
      fault_stops_permanently = (k == 7);
      if (k == 6) begin
        repeat (4) begin
          flt = 8'h40;
          cyc(1 + {$random(seed)} % (AH - 2));
          flt = 8'h00;
          cyc(1);
        end
        `CHK("short avg pulses", 1'b0, system_in_fault)
      end
      flt = 8'h01 << k;
      `WAIT(system_in_fault, AL + 10)
      `CHK("fault latency", 1'b1, n + 1 >= fault_lat(k) && n <= fault_lat(k) + 2)
      flt = 8'h00;
      `CHK("fault enables", 5'h00, en)
      `WAIT(!system_in_fault, FP + 10)
      `CHK("restart", k != 7, !system_in_fault)
    end
    reset = 1;
    cyc(2);
    reset = 0;
    `CHK("second reset", EN_RESET, en)
    $display("test faults done");
    // disconnect detector, plain then latched supply regulation
    for (k = 0; k < 2; k++) begin
      supply_regulation_latched = k;
      `WAIT(xcap_test_current_on, IDL + 10)
      `WAIT(!xcap_test_current_on, WIN)
      `CHK("stop on crossing", 1'b1, n <= 8)
      mains_on = 0;
      `WAIT(xcap_test_current_on, IDL + 10)
      `CHK("idle gap", 1'b1, n >= IDL - 1 && n <= IDL + 2)
      cyc(6 * WIN);
      `CHK("top step", TOP_STEP, xcap_test_current_step)
      `WAIT(filter_cap_discharge_request, 2 * WIN)
      `CHK("disconnect time", 1'b1, n >= WIN - 1 && n <= WIN + 2)
      cyc(1);
      `CHK("switch opens first", !k, fet_supply_switch_closed)
      cyc(1);
      `CHK("sink on", 1'b1, filter_cap_discharge_current)
      `CHK("fet on for sink", 1'b1, startup_fet_on)
      `CHK("separate request", 1'b1, filter_cap_discharge_request)
      `WAIT(!filter_cap_discharge_request, DIS + 5)
      `CHK("discharge time", 1'b1, n + 2 >= DIS - 1 && n + 2 <= DIS + 1)
      cyc(1);
      `CHK("sink off", 1'b0, filter_cap_discharge_current)
      `CHK("switch held open", !k, fet_supply_switch_closed)
      cyc(1);
      `CHK("switch closed", 1'b1, fet_supply_switch_closed)
      mains_on = 1;
    end
    $display("test detector done");
    complete_run();
  end
endmodule
